// *** src/asc_pkg.sv ***
// Shared constants, field layouts and types for the serial ADC conversion control block.
package asc_pkg;

    // System clock and conversion timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_TIME_NS = 4000;
    localparam int START_MIN_HIGH_NS = 40;

    // Data widths and serial frame lengths.
    localparam int RESULT_W = 16;
    localparam int CFG_W = 8;
    localparam int XFER_BITS = 16;
    localparam int ACQ_FALL_INDEX = 5;
    localparam int NAP_WAKE_FALL_INDEX = 1;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SAMPLE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0c;

    // Control register: resolution variant in the low two bits.
    localparam int CTRL_RES_LSB = 0;
    localparam logic [1:0] RES_16 = 2'h0;
    localparam logic [1:0] RES_14 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;
    localparam logic [15:0] MOST_POSITIVE_CODE = 16'h7fff;

    // Status register field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_ACQ = 1;
    localparam int ST_PWR_LSB = 2;
    localparam int ST_CFG_VALID = 4;
    localparam int ST_CFG_LSB = 8;

    // Configuration word as it arrives, first bit in the top position.
    typedef struct packed {
        logic single_diff_select;
        logic odd_sign;
        logic [1:0] select;
        logic [1:0] dont_care;
        logic nap;
        logic sleep;
    } asc_config_t;

    // Multiplexer routing that the configuration word selects.
    typedef struct packed {
        logic [2:0] pos_channel;
        logic [2:0] neg_channel;
        logic neg_common;
    } asc_mux_t;

    // Power-down modes.
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_NAP,
        PWR_SLEEP
    } asc_power_t;

    // Progress of the configuration word within a serial transfer.
    typedef enum logic [1:0] {
        XF_WAIT,
        XF_CONFIG,
        XF_DATA
    } asc_xfer_t;

endpackage

// *** src/asc_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
module asc_sync
    import asc_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    generate
        if (WIDTH < 1) begin : g_check
            $error("asc_sync needs at least one bit");
        end
    endgenerate

    // The first stage feeds only the second stage, so metastability cannot spread.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// *** src/asc_conv_timer.sv ***
// Conversion timer standing in for the converter's internal clock.
module asc_conv_timer
    import asc_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Start request and progress.
    input wire logic start,
    output logic busy,
    output logic done
);

    localparam int CNT_W = $clog2(CYCLES + 1);

    logic [CNT_W-1:0] count_reg;

    generate
        if (CYCLES < 1) begin : g_check
            $error("asc_conv_timer needs a count of at least one cycle");
        end
    endgenerate

    // A start while running is dropped here as well, so a conversion cannot restart.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (busy) begin
                if (count_reg == CNT_W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count_reg <= count_reg - CNT_W'(1);
            end else if (start) begin
                busy <= 1'b1;
                count_reg <= CNT_W'(CYCLES);
            end
        end
    end

endmodule

// *** src/asc_top.sv ***
// Serial conversion control of an eight-channel successive-approximation converter.
// Notes on behaviour
// - Results are two's complement, most positive 7fff.
// - Internal timer ends each conversion after 4us.
// - Start requests during a conversion are ignored.
// - Busy is low throughout every conversion.
// - 12/14-bit variants zero the last bits.
// - Read tied low keeps serial output enabled.
// - Read high keeps serial output tristated.
// - Launch on falling clock, capture on rising.
// - Previous result shifts out during configuration.
// - Result appears on the transfer after conversion.
// - Only first eight rising edges take configuration.
// - Differential mode picks pair and polarity.
// - Single-ended picks channel against common input.
// - Mux from first four bits, power last two.
// - Nap, power on, or sleep per bits.
// - Acquire from sixth falling edge to start.
// - Read high ignores clock and data in.
//
// Implementation choices: the register offsets and register access over Wishbone.
module asc_top
    import asc_pkg::*;
#(
    parameter int CONV_CYCLES_P = CONV_CYCLES
) (
    // System clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter pins from the host.
    input wire logic conversion_start,
    input wire logic read_n,
    input wire logic serial_clock,
    input wire logic serial_in,
    // Converter pins to the host.
    output logic busy_n,
    output logic serial_out,
    output logic serial_out_oe_n,
    // Analog front-end controls.
    output logic [2:0] mux_pos_channel,
    output logic [2:0] mux_neg_channel,
    output logic mux_neg_common,
    output logic acquire,
    output logic [1:0] power_mode
);

    // Synchronised pins and edge history.
    logic [3:0] pins_sync;
    logic start_s;
    logic read_n_s;
    logic sck_s;
    logic sdi_s;
    logic start_prev_reg;
    logic sck_prev_reg;
    logic sck_rise;
    logic sck_fall;
    logic start_pulse;

    // Conversion progress.
    logic conv_busy;
    logic conv_done;

    // Serial transfer state.
    asc_xfer_t xfer_reg;
    logic [4:0] rise_count_reg;
    logic [4:0] fall_count_reg;
    logic [CFG_W-1:0] cfg_shift_reg;
    logic [CFG_W-1:0] cfg_word;
    logic [RESULT_W-1:0] out_shift_reg;

    // Configuration, power and result.
    asc_config_t config_reg;
    logic config_valid_reg;
    asc_mux_t mux_reg;
    asc_power_t power_reg;
    logic acquire_reg;
    logic [RESULT_W-1:0] result_reg;

    // Software registers.
    logic [1:0] res_reg;
    logic [RESULT_W-1:0] sample_reg;
    logic bus_req;
    logic bus_write;
    logic [DATA_W-1:0] read_value;

    // Clear the bits below the variant's resolution.
    function automatic logic [RESULT_W-1:0] apply_resolution(input logic [RESULT_W-1:0] code,
                                                             input logic [1:0] res);
        logic [RESULT_W-1:0] masked;
        masked = code;
        case (res)
            RES_14: masked = {code[RESULT_W-1:2], 2'h0};
            RES_12: masked = {code[RESULT_W-1:4], 4'h0};
            default: masked = code;
        endcase
        return masked;
    endfunction

    // Turn a configuration word into multiplexer routing.
    function automatic asc_mux_t decode_mux(input asc_config_t cfg);
        asc_mux_t m;
        m.pos_channel = {cfg.select, cfg.odd_sign};
        m.neg_channel = {cfg.select, ~cfg.odd_sign};
        m.neg_common = cfg.single_diff_select;
        return m;
    endfunction

    // Merge a write into a 16-bit register under the byte enables.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] sel);
        logic [15:0] merged;
        merged = old;
        if (sel[0]) begin
            merged[7:0] = data[7:0];
        end
        if (sel[1]) begin
            merged[15:8] = data[15:8];
        end
        return merged;
    endfunction

    // Every pin passes two flip-flops before any logic looks at it.
    asc_sync #(
        .WIDTH(4)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in({conversion_start, read_n, serial_clock, serial_in}),
        .sync_out(pins_sync)
    );

    assign start_s = pins_sync[3];
    assign read_n_s = pins_sync[2];
    assign sck_s = pins_sync[1];
    assign sdi_s = pins_sync[0];

    // Edge history of the synchronised start and serial clock.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            start_prev_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_s;
            sck_prev_reg <= sck_s;
        end
    end

    // With read high the serial clock is not seen at all.
    assign sck_rise = !read_n_s && sck_s && !sck_prev_reg;
    assign sck_fall = !read_n_s && !sck_s && sck_prev_reg;
    // A start pulse shorter than a clock period may slip between samples.
    assign start_pulse = start_s && !start_prev_reg && !conv_busy;
    assign cfg_word = {cfg_shift_reg[CFG_W-2:0], sdi_s};

    // The conversion itself is timed by its own counter.
    asc_conv_timer #(
        .CYCLES(CONV_CYCLES_P)
    ) u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .start(start_pulse),
        .busy(conv_busy),
        .done(conv_done)
    );

    assign busy_n = !conv_busy;

    // Edge counters and frame progress; a new conversion opens a new frame.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rise_count_reg <= 5'h00;
            fall_count_reg <= 5'h00;
            xfer_reg <= XF_WAIT;
        end else if (start_pulse) begin
            rise_count_reg <= 5'h00;
            fall_count_reg <= 5'h00;
            xfer_reg <= XF_WAIT;
        end else begin
            if (sck_rise && rise_count_reg != 5'(XFER_BITS)) begin
                rise_count_reg <= rise_count_reg + 5'h01;
            end
            if (sck_fall && fall_count_reg != 5'(XFER_BITS)) begin
                fall_count_reg <= fall_count_reg + 5'h01;
            end
            case (xfer_reg)
                XF_WAIT: begin
                    if (sck_rise) begin
                        xfer_reg <= XF_CONFIG;
                    end
                end
                XF_CONFIG: begin
                    if (sck_rise && rise_count_reg == 5'(CFG_W - 1)) begin
                        xfer_reg <= XF_DATA;
                    end
                end
                XF_DATA: xfer_reg <= XF_DATA;
                default: xfer_reg <= XF_WAIT;
            endcase
        end
    end

    // Configuration bits are captured on rising edges, then input is ignored.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cfg_shift_reg <= 8'h00;
            config_reg <= '0;
            config_valid_reg <= 1'b0;
        end else if (sck_rise && xfer_reg != XF_DATA) begin
            cfg_shift_reg <= cfg_word;
            if (rise_count_reg == 5'(CFG_W - 1)) begin
                config_reg <= asc_config_t'(cfg_word);
                config_valid_reg <= 1'b1;
            end
        end
    end

    // Routing follows the latched word, so it changes at the eighth rising edge, after acquisition has begun, and holds through hold.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mux_reg <= '0;
        end else begin
            mux_reg <= decode_mux(config_reg);
        end
    end

    assign mux_pos_channel = mux_reg.pos_channel;
    assign mux_neg_channel = mux_reg.neg_channel;
    assign mux_neg_common = mux_reg.neg_common;

    // Acquisition runs from the sixth falling edge to the start of conversion.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acquire_reg <= 1'b0;
        end else if (start_pulse) begin
            acquire_reg <= 1'b0;
        end else if (sck_fall && fall_count_reg == 5'(ACQ_FALL_INDEX)) begin
            acquire_reg <= 1'b1;
        end
    end

    assign acquire = acquire_reg;

    // Nap waits for the end of conversion; sleep changes on the last falling edge.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            power_reg <= PWR_ON;
        end else if (sck_fall && fall_count_reg == 5'(XFER_BITS - 1)) begin
            if (config_reg.sleep) begin
                power_reg <= PWR_SLEEP;
            end else if (power_reg == PWR_SLEEP) begin
                power_reg <= PWR_ON;
            end
        end else if (conv_done && config_reg.nap && !config_reg.sleep) begin
            power_reg <= PWR_NAP;
        end else if (sck_fall && fall_count_reg == 5'(NAP_WAKE_FALL_INDEX)
                     && power_reg == PWR_NAP) begin
            power_reg <= PWR_ON;
        end
    end

    assign power_mode = power_reg;

    // The finished code is loaded for the next transfer and shifted out MSB first.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            result_reg <= 16'h0000;
            out_shift_reg <= 16'h0000;
        end else if (conv_done) begin
            result_reg <= apply_resolution(sample_reg, res_reg);
            out_shift_reg <= apply_resolution(sample_reg, res_reg);
        end else if (sck_fall) begin
            out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
        end
    end

    // Read low drives the pin; read high tristates it, whatever start does.
    assign serial_out = out_shift_reg[RESULT_W-1];
    assign serial_out_oe_n = read_n_s;

    // Bus request decode; the write lands on the edge that samples ack.
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_write = bus_req && wb_we_i && wb_ack_o;

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        read_value = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_CTRL: read_value[CTRL_RES_LSB +: 2] = res_reg;
            ADDR_SAMPLE: read_value[RESULT_W-1:0] = sample_reg;
            ADDR_STATUS: begin
                read_value[ST_BUSY] = conv_busy;
                read_value[ST_ACQ] = acquire_reg;
                read_value[ST_PWR_LSB +: 2] = power_reg;
                read_value[ST_CFG_VALID] = config_valid_reg;
                read_value[ST_CFG_LSB +: CFG_W] = config_reg;
            end
            ADDR_RESULT: read_value[RESULT_W-1:0] = result_reg;
            default: read_value = 32'h0000_0000;
        endcase
    end

    // One wait state, then ack for one cycle; ack drops the cycle after.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= read_value;
            end
        end
    end

    // Writable registers: resolution variant and the code the converter produces.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            res_reg <= CTRL_RESET;
            sample_reg <= SAMPLE_RESET;
        end else if (bus_write) begin
            if (wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
                res_reg <= wb_dat_i[CTRL_RES_LSB +: 2];
            end
            if (wb_adr_i == ADDR_SAMPLE) begin
                sample_reg <= merge16(sample_reg, wb_dat_i, wb_sel_i);
            end
        end
    end

endmodule

// *** testbench/asc_checker.sv ***
// Port assertions for the serial conversion control block.
module asc_checker
    import asc_pkg::*;
#(
    parameter int CONV_CYCLES_P = CONV_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Host pins.
    input wire logic conversion_start,
    input wire logic read_n,
    input wire logic busy_n,
    input wire logic serial_out_oe_n,
    // Front-end controls.
    input wire logic [2:0] mux_pos_channel,
    input wire logic [2:0] mux_neg_channel,
    input wire logic mux_neg_common,
    input wire logic acquire,
    input wire logic [1:0] power_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [15:0] low_count;
    // Counts busy cycles, so a restarted or stretched conversion shows up.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            low_count <= 16'h0000;
        end else if (busy_n) begin
            low_count <= 16'h0000;
        end else begin
            low_count <= low_count + 16'h0001;
        end
    end
    property p_busy_length;
        $rose(busy_n) |-> low_count == 16'(CONV_CYCLES_P);
    endproperty
    a_busy_length: assert property (p_busy_length)
        else $error("Busy period has the wrong length.");
    property p_no_restart;
        low_count <= 16'(CONV_CYCLES_P);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("Conversion ran past its length.");
    property p_busy_cause;
        $fell(busy_n) |-> $past(conversion_start, 2) || $past(conversion_start, 3);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("Busy fell without a start edge.");
    property p_read_off;
        read_n [*4] |-> serial_out_oe_n;
    endproperty
    a_read_off: assert property (p_read_off)
        else $error("Output driven while read is high.");
    property p_read_on;
        !read_n [*4] |-> !serial_out_oe_n;
    endproperty
    a_read_on: assert property (p_read_on)
        else $error("Output not driven while read is low.");
    property p_mux_pair;
        $changed(mux_pos_channel) && !mux_neg_common |->
            mux_neg_channel == {mux_pos_channel[2:1], ~mux_pos_channel[0]};
    endproperty
    a_mux_pair: assert property (p_mux_pair)
        else $error("Differential pair is not adjacent.");
    property p_mux_hold;
        !busy_n |-> $stable(mux_pos_channel) && $stable(mux_neg_common);
    endproperty
    a_mux_hold: assert property (p_mux_hold)
        else $error("Routing changed during a conversion.");
    property p_acq_end;
        !busy_n |-> !acquire;
    endproperty
    a_acq_end: assert property (p_acq_end)
        else $error("Acquisition during a conversion.");
    property p_acq_start;
        $rose(acquire) |-> busy_n && !serial_out_oe_n;
    endproperty
    a_acq_start: assert property (p_acq_start)
        else $error("Acquisition began outside a frame.");
    property p_power_legal;
        power_mode != 2'h3;
    endproperty
    a_power_legal: assert property (p_power_legal)
        else $error("Illegal power mode.");
    c_conv: cover property ($rose(busy_n));
    c_acq: cover property ($rose(acquire));
    c_nap: cover property (power_mode == 2'h1);
    c_sleep: cover property (power_mode == 2'h2);
endmodule

bind asc_top asc_checker #(.CONV_CYCLES_P(CONV_CYCLES_P)) u_checker (.clock, .reset_n,
    .conversion_start, .read_n, .busy_n, .serial_out_oe_n, .mux_pos_channel,
    .mux_neg_channel, .mux_neg_common, .acquire, .power_mode);

// *** testbench/asc_host.sv ***
// Behavioural host that drives the converter pins and reads results.
module asc_host (
    // Clock and converter status.
    input wire logic clock,
    input wire logic busy_n,
    input wire logic serial_out,
    // Pins the host drives.
    output logic conversion_start,
    output logic read_n,
    output logic serial_clock,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tied;
    logic [15:0] rx;
    int run;
    int lo;
    // Read is tied low by default; the serial clock rests low between frames.
    initial begin
        conversion_start = 1'b0;
        read_n = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b0;
        tied = 1'b0;
        run = 0;
        lo = 0;
    end
    // Measures each busy period so a restart attempt can be judged.
    always @(negedge clock) begin
        if (!busy_n) begin
            run <= run + 1;
        end else if (run != 0) begin
            lo <= run;
            run <= 0;
        end
    end
    // One full-duplex frame: launch on the fall, capture on the rise.
    task automatic frame(input logic [7:0] cfg);
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            serial_in <= (i < 8) ? cfg[7-i] : i[0];
            repeat (4) @(posedge clock);
            serial_clock <= 1'b1;
            rx[15-i] <= serial_out;
            repeat (4) @(posedge clock);
            serial_clock <= 1'b0;
        end
        repeat (4) @(posedge clock);
    endtask
    // Start pulse well over the minimum width; optionally a second one mid-run.
    task automatic start(input logic again);
        @(posedge clock);
        conversion_start <= 1'b1;
        if (tied) begin
            read_n <= 1'b1;
        end
        repeat (4) @(posedge clock);
        if (!tied) begin
            conversion_start <= 1'b0;
        end
        while (busy_n) @(negedge clock);
        if (again) begin
            @(posedge clock);
            conversion_start <= 1'b1;
            repeat (4) @(posedge clock);
            conversion_start <= 1'b0;
        end
        while (!busy_n) @(negedge clock);
        if (tied) begin
            @(posedge clock);
            conversion_start <= 1'b0;
            read_n <= 1'b0;
        end
        @(negedge clock);
    endtask
    // Changes the read enable and lets the synchroniser settle.
    task automatic set_read(input logic v);
        @(posedge clock);
        read_n <= v;
        repeat (4) @(posedge clock);
    endtask
endmodule

// *** testbench/adc_serial_conversion_control_test.sv ***
// Self-checking bench for the serial conversion control block.
module adc_serial_conversion_control_test
    import asc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CV = 20;
    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] smp;
        logic [1:0] res;
        logic [6:0] mux;
        logic [1:0] pwr;
        logic [15:0] result;
    } asc_row_t;
    // Configuration, sample and resolution beside routing, power and result.
    asc_row_t rows [8] = '{
        '{8'h00, 16'h7fff, 2'h0, 7'h02, 2'h0, 16'h7fff},
        '{8'h50, 16'h8000, 2'h1, 7'h34, 2'h0, 16'h8000},
        '{8'ha2, 16'h1234, 2'h2, 7'h4b, 2'h1, 16'h1230},
        '{8'hfd, 16'hffff, 2'h1, 7'h7d, 2'h2, 16'hfffc},
        '{8'h33, 16'h0001, 2'h0, 7'h6e, 2'h2, 16'h0001},
        '{8'hc0, 16'ha5a5, 2'h3, 7'h11, 2'h0, 16'ha5a5},
        '{8'h6c, 16'h5a5a, 2'h2, 7'h58, 2'h0, 16'h5a50},
        '{8'h90, 16'h7ffe, 2'h0, 7'h27, 2'h0, 16'h7ffe}};
    logic clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [DATA_W-1:0] wb_dat_i, wb_dat_o, q;
    logic conversion_start, read_n, serial_clock, serial_in;
    logic busy_n, serial_out, serial_out_oe_n, mux_neg_common, acquire;
    logic [2:0] mux_pos_channel, mux_neg_channel;
    logic [1:0] power_mode;
    int mismatches = 0;
    int tests_run = 0;
    logic [3:0] sel = 4'hf;
    asc_top #(.CONV_CYCLES_P(CV)) u_dut (.clock, .reset_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .conversion_start, .read_n, .serial_clock, .serial_in, .busy_n, .serial_out,
        .serial_out_oe_n, .mux_pos_channel, .mux_neg_channel, .mux_neg_common,
        .acquire, .power_mode);
    asc_host u_host (.clock, .busy_n, .serial_out, .conversion_start, .read_n,
        .serial_clock, .serial_in);
    // The system clock at 20 MHz.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single Wishbone cycle; the request stands until ack is sampled.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // A hang is cut short well after the expected run length.
    initial begin
        #1000000;
        mismatches++;
        stop_test();
    end
    // Main sequence: table rows first, then the awkward cases.
    initial begin
        reset_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        wb(1'b0, ADDR_CTRL, 32'h0, q);
        chk(q, 32'(CTRL_RESET));
        wb(1'b0, ADDR_SAMPLE, 32'h0, q);
        chk(q, 32'(SAMPLE_RESET));
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, ADDR_SAMPLE, 32'(rows[i].smp), q);
            wb(1'b1, ADDR_CTRL, 32'(rows[i].res), q);
            u_host.frame(rows[i].cfg);
            if (i > 0) begin
                chk(32'(u_host.rx), 32'(rows[i-1].result));
            end
            chk(32'({mux_pos_channel, mux_neg_channel, mux_neg_common}),
                32'(rows[i].mux));
            chk(32'(acquire), 32'h1);
            u_host.start(1'b0);
            chk(32'(power_mode), 32'(rows[i].pwr));
            wb(1'b0, ADDR_RESULT, 32'h0, q);
            chk(q, 32'(rows[i].result));
        end
        u_host.frame(8'h00);
        chk(32'(u_host.rx), 32'(rows[7].result));
        u_host.frame(8'hc0);
        chk(32'({mux_pos_channel, mux_neg_channel, mux_neg_common}), 32'h02);
        u_host.start(1'b1);
        chk(32'(u_host.lo), 32'(CV));
        u_host.set_read(1'b1);
        u_host.frame(8'hfd);
        chk(32'(serial_out_oe_n), 32'h1);
        chk(32'({mux_pos_channel, power_mode}), 32'h0);
        u_host.set_read(1'b0);
        chk(32'(serial_out_oe_n), 32'h0);
        u_host.frame(8'h50);
        chk(32'({mux_pos_channel, mux_neg_channel, mux_neg_common}), 32'h34);
        u_host.tied = 1'b1;
        u_host.start(1'b0);
        chk(32'(serial_out_oe_n), 32'h1);
        repeat (4) @(negedge clock);
        chk(32'(serial_out_oe_n), 32'h0);
        wb(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q, 32'h0000_5010);
        wb(1'b1, 8'hf3, 32'hffff_ffff, q);
        wb(1'b0, 8'hf3, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b1, ADDR_RESULT, 32'h1234, q);
        wb(1'b0, ADDR_RESULT, 32'h0, q);
        chk(q, 32'(rows[7].result));
        // Only byte lane 1 is enabled, so the low byte must survive.
        sel = 4'h2;
        wb(1'b1, ADDR_SAMPLE, 32'h0000_abcd, q);
        sel = 4'hf;
        wb(1'b0, ADDR_SAMPLE, 32'h0, q);
        chk(q, 32'h0000_abfe);
        @(posedge clock);
        reset_n <= 1'b0;
        @(negedge clock);
        chk(32'({busy_n, acquire, power_mode, wb_ack_o, mux_pos_channel}), 32'h80);
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        wb(1'b0, ADDR_CTRL, 32'h0, q);
        chk(q, 32'(CTRL_RESET));
        stop_test();
    end
endmodule
